//--- rtl/asstx_defines.vh
// constants for the subtract, swap, mask-test and exclusive-or datapath slice
`ifndef ASSTX_DEFINES_VH
`define ASSTX_DEFINES_VH
// flag register bit positions
`define ASSTX_FLAG_C 7
`define ASSTX_FLAG_Z 6
`define ASSTX_FLAG_S 5
`define ASSTX_FLAG_V 4
`define ASSTX_FLAG_D 3
`define ASSTX_FLAG_H 2
`define ASSTX_FLAGS_RESET 8'h00
// opcode high nibbles of each instruction family
`define ASSTX_OPH_SUB 4'h2
`define ASSTX_OPH_MASK 4'h7
`define ASSTX_OPH_XOR 4'hb
`define ASSTX_OPH_SWAP 4'hf
// opcode low nibbles of each operand form
`define ASSTX_OPL_RR 4'h2
`define ASSTX_OPL_RIR 4'h3
`define ASSTX_OPL_FR 4'h4
`define ASSTX_OPL_FIR 4'h5
`define ASSTX_OPL_IMR 4'h6
`define ASSTX_OPL_IMIR 4'h7
`define ASSTX_OPL_SWR 4'h0
`define ASSTX_OPL_SWIR 4'h1
// cycle counts
`define ASSTX_CYC_WORK 4'h6
`define ASSTX_CYC_FULL 4'ha
`define ASSTX_CYC_SWAP 4'h8
// escape nibble marking a working-register operand
`define ASSTX_WREG_ESC 4'he
`endif

//--- rtl/asstx_decode.v
// opcode decoder: operation, operand modes and cycle count
`timescale 1ns/10ps
`include "asstx_defines.vh"
module asstx_decode (
	// opcode in
	input wire [7:0] i_opcode,
	// decode out
	output reg o_valid,
	output reg [3:0] o_op,
	output reg o_src_work,
	output reg o_pointer_operand_mode,
	output reg o_literal_operand_mode,
	output reg o_dst_pointer,
	output reg [3:0] o_cycles
);
	// split the opcode into family and form
	always @* begin
		o_valid = 1'b0;
		o_op = i_opcode[7:4];
		o_src_work = 1'b0;
		o_pointer_operand_mode = 1'b0;
		o_literal_operand_mode = 1'b0;
		o_dst_pointer = 1'b0;
		o_cycles = 4'h0;
		if (i_opcode[7:4] == `ASSTX_OPH_SWAP) begin
			o_valid = (i_opcode[3:1] == 3'h0);
			o_dst_pointer = i_opcode[0];
			o_cycles = `ASSTX_CYC_SWAP;
		end else if (i_opcode[7:4] == `ASSTX_OPH_SUB || i_opcode[7:4] == `ASSTX_OPH_MASK ||
				i_opcode[7:4] == `ASSTX_OPH_XOR) begin
			case (i_opcode[3:0])
			`ASSTX_OPL_RR, `ASSTX_OPL_RIR: begin
				o_valid = 1'b1;
				o_src_work = 1'b1;
				o_pointer_operand_mode = i_opcode[0];
				o_cycles = `ASSTX_CYC_WORK;
			end
			`ASSTX_OPL_FR, `ASSTX_OPL_FIR: begin
				o_valid = 1'b1;
				o_pointer_operand_mode = i_opcode[0];
				o_cycles = `ASSTX_CYC_FULL;
			end
			`ASSTX_OPL_IMR, `ASSTX_OPL_IMIR: begin
				o_valid = 1'b1;
				o_literal_operand_mode = 1'b1;
				o_dst_pointer = i_opcode[0];
				o_cycles = `ASSTX_CYC_FULL;
			end
			default: begin
				o_valid = 1'b0;
			end
			endcase
		end
	end
endmodule // asstx_decode

//--- rtl/asstx_alu.v
// eight-bit datapath for subtract, nibble swap, mask test and exclusive or
`timescale 1ns/10ps
`include "asstx_defines.vh"
// Notes on behaviour
// - subtract adds two's complement of source
// - subtract forms take six or ten cycles
// - carry set means borrow out of bit 7
// - half-carry set means borrow from low nibble
// - overflow on opposite signs, result matches source
// - zero, sign follow result; decimal flag forced one
// - swap exchanges nibbles, eight cycles
// - swap sets zero, sign; keeps half, decimal
// - mask test ANDs, destination left untouched
// - mask test sets zero, sign; clears overflow
// - exclusive or stores differing bits
// - exclusive or clears overflow, keeps carry, half, decimal
// - working register operand: escape nibble plus number
module asstx_alu (
	// clock and reset
	input wire i_core_clk,
	input wire i_reset_n,
	// instruction start from the decoder
	input wire i_start,
	input wire [7:0] i_opcode,
	// operand bytes from the register file
	input wire [7:0] i_dst_data,
	input wire [7:0] i_src_data,
	// operand address bytes as fetched
	input wire [7:0] i_dst_addr,
	input wire [7:0] i_src_addr,
	// flag register loaded by other instructions
	input wire i_flags_load,
	input wire [7:0] i_flags_data,
	// results
	output reg o_busy,
	output reg o_done,
	output reg o_illegal,
	output reg o_wr_en,
	output reg [7:0] o_wr_data,
	output reg [7:0] o_flags,
	// operand address decode for the register file
	output reg o_dst_work,
	output reg [3:0] o_dst_wreg,
	output reg o_src_work,
	output reg [3:0] o_src_wreg,
	output reg o_pointer_operand_mode,
	output reg o_literal_operand_mode
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	// escape-coded operand test, used for both operands
	function is_work;
		input [7:0] addr;
		begin
			is_work = (addr[7:4] == `ASSTX_WREG_ESC);
		end
	endfunction

	// sequencer state, countdown and decoder outputs
	reg [1:0] state;
	reg [3:0] count;
	wire dec_valid;
	wire [3:0] dec_op;
	wire dec_src_work;
	wire dec_ptr;
	wire dec_lit;
	wire dec_dst_ptr;
	wire [3:0] dec_cycles;
	reg [7:0] next_result;
	reg next_wr;
	reg [7:0] next_flags;
	reg [8:0] sum;
	reg [4:0] half;
	// write-back strobe held for the whole instruction
	reg op_writes;

	// ------------------------------------------------------------
	// opcode decode
	// ------------------------------------------------------------
	asstx_decode u_decode (
		.i_opcode(i_opcode),
		.o_valid(dec_valid),
		.o_op(dec_op),
		.o_src_work(dec_src_work),
		.o_pointer_operand_mode(dec_ptr),
		.o_literal_operand_mode(dec_lit),
		.o_dst_pointer(dec_dst_ptr),
		.o_cycles(dec_cycles)
	);

	// ------------------------------------------------------------
	// result and flag computation
	// ------------------------------------------------------------
	always @* begin
		next_result = i_dst_data;
		next_wr = 1'b0;
		next_flags = o_flags;
		// a missing carry out of bit 7 or bit 3 is the borrow
		sum = {1'b0, i_dst_data} + {1'b0, ~i_src_data} + 9'h001;
		half = {1'b0, i_dst_data[3:0]} + {1'b0, ~i_src_data[3:0]} + 5'h01;
		case (dec_op)
		`ASSTX_OPH_SUB: begin
			next_result = sum[7:0];
			next_wr = 1'b1;
			next_flags[`ASSTX_FLAG_C] = ~sum[8];
			next_flags[`ASSTX_FLAG_H] = ~half[4];
			next_flags[`ASSTX_FLAG_V] = (i_dst_data[7] ^ i_src_data[7]) &
				(sum[7] == i_src_data[7]);
			next_flags[`ASSTX_FLAG_Z] = (sum[7:0] == 8'h00);
			next_flags[`ASSTX_FLAG_S] = sum[7];
			next_flags[`ASSTX_FLAG_D] = 1'b1;
		end
		`ASSTX_OPH_SWAP: begin
			next_result = {i_dst_data[3:0], i_dst_data[7:4]};
			next_wr = 1'b1;
			next_flags[`ASSTX_FLAG_Z] = (i_dst_data == 8'h00);
			next_flags[`ASSTX_FLAG_S] = i_dst_data[3];
		end
		`ASSTX_OPH_MASK: begin
			next_result = i_dst_data & i_src_data;
			next_wr = 1'b0;
			next_flags[`ASSTX_FLAG_Z] = ((i_dst_data & i_src_data) == 8'h00);
			next_flags[`ASSTX_FLAG_S] = i_dst_data[7] & i_src_data[7];
			next_flags[`ASSTX_FLAG_V] = 1'b0;
		end
		`ASSTX_OPH_XOR: begin
			next_result = i_dst_data ^ i_src_data;
			next_wr = 1'b1;
			next_flags[`ASSTX_FLAG_Z] = ((i_dst_data ^ i_src_data) == 8'h00);
			next_flags[`ASSTX_FLAG_S] = i_dst_data[7] ^ i_src_data[7];
			next_flags[`ASSTX_FLAG_V] = 1'b0;
		end
		default: begin
			next_wr = 1'b0;
		end
		endcase
	end

	// ------------------------------------------------------------
	// sequencer: data and flags load at start; done and write strobe follow the documented cycle count
	// ------------------------------------------------------------
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ST_IDLE;
			count <= 4'h0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_illegal <= 1'b0;
			o_wr_en <= 1'b0;
			o_wr_data <= 8'h00;
			o_flags <= `ASSTX_FLAGS_RESET;
			o_dst_work <= 1'b0;
			o_dst_wreg <= 4'h0;
			o_src_work <= 1'b0;
			o_src_wreg <= 4'h0;
			o_pointer_operand_mode <= 1'b0;
			o_literal_operand_mode <= 1'b0;
		end else begin
			o_done <= 1'b0;
			o_wr_en <= 1'b0;
			o_illegal <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (i_start) begin
					if (dec_valid) begin
						// operands are captured at start; source never written
						o_wr_data <= next_result;
						o_wr_en <= 1'b0;
						o_dst_work <= is_work(i_dst_addr) | dec_src_work;
						o_dst_wreg <= i_dst_addr[3:0];
						o_src_work <= is_work(i_src_addr) | dec_src_work;
						o_src_wreg <= i_src_addr[3:0];
						o_pointer_operand_mode <= dec_ptr | dec_dst_ptr;
						o_literal_operand_mode <= dec_lit;
						count <= dec_cycles - 4'h1;
						o_busy <= 1'b1;
						state <= ST_RUN;
						if (next_wr) begin
							o_wr_data <= next_result;
						end
						o_flags <= next_flags;
						o_wr_en <= 1'b0;
					end else begin
						o_illegal <= 1'b1;
					end
				end else if (i_flags_load) begin
					o_flags <= i_flags_data;
				end
			end
			ST_RUN: begin
				// count down; the last tick raises done with the write strobe
				count <= count - 4'h1;
				if (count == 4'h1) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
					o_wr_en <= op_writes;
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// remember whether the running instruction writes back
	// ------------------------------------------------------------
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			op_writes <= 1'b0;
		end else if (state == ST_IDLE && i_start && dec_valid) begin
			op_writes <= next_wr;
		end
	end
endmodule // asstx_alu

//--- sim/asstx_alu_monitor.sv
// port-level assertions for the subtract, swap, mask-test and exclusive-or datapath
`timescale 1ns/10ps
module asstx_alu_monitor (
	// clock and reset
	input wire i_core_clk,
	input wire i_reset_n,
	// instruction request
	input wire i_start,
	input wire [7:0] i_opcode,
	input wire [7:0] i_dst_data,
	input wire [7:0] i_src_data,
	// results
	input wire o_busy,
	input wire o_done,
	input wire o_wr_en,
	input wire [7:0] o_wr_data,
	input wire [7:0] o_flags
);
	// operands and flags one cycle back
	reg [7:0] pd;
	reg [7:0] ps;
	reg [7:0] pf;
	// accepted starts per family, short forms
	wire tk = i_start & ~o_busy;
	wire lf = (i_opcode[3:0] > 4'h1) && (i_opcode[3:0] < 4'h8);
	wire sb = tk && lf && i_opcode[7:4] == 4'h2;
	wire mk = tk && lf && i_opcode[7:4] == 4'h7;
	wire xr = tk && lf && i_opcode[7:4] == 4'hb;
	wire sw = tk && i_opcode[7:1] == 7'h78;
	wire sh = i_opcode[3:2] == 2'b00;
	// history registers
	always @(posedge i_core_clk) begin
		pd <= i_dst_data;
		ps <= i_src_data;
		pf <= o_flags;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	a_sub_result: assert property (sb |=> o_wr_data == pd - ps && o_flags[3])
		else $error("subtract result wrong");
	a_sub_borrow: assert property (sb |=> o_flags[7] == (pd < ps)
		&& o_flags[2] == (pd[3:0] < ps[3:0])) else $error("subtract borrow wrong");
	a_sub_ovf: assert property (sb |=> o_flags[4] == ((pd[7] ^ ps[7]) && o_wr_data[7] == ps[7]))
		else $error("subtract overflow wrong");
	a_zero_sign: assert property ((sb || xr || sw) |=>
		o_flags[6] == (o_wr_data == 8'h00) && o_flags[5] == o_wr_data[7]) else $error("zero or sign");
	a_mask_flags: assert property (mk |=> o_flags[6] == ((pd & ps) == 8'h00)
		&& o_flags[5] == (pd[7] & ps[7]) && !o_flags[4] && o_flags[7] == pf[7]
		&& o_flags[3:2] == pf[3:2]) else $error("mask test flags wrong");
	a_mask_nowrite: assert property (mk |=> !o_wr_en [*8] ##1 !o_wr_en ##1 !o_wr_en)
		else $error("mask test wrote back");
	a_xor_result: assert property (xr |=> o_wr_data == (pd ^ ps) && !o_flags[4]
		&& o_flags[7] == pf[7] && o_flags[3:2] == pf[3:2]) else $error("xor result wrong");
	a_swap_result: assert property (sw |=> o_wr_data == {pd[3:0], pd[7:4]}
		&& o_flags[3:2] == pf[3:2]) else $error("swap result wrong");
	a_short_timing: assert property ((sb || mk || xr) && sh |-> ##5 !o_done ##1 o_done)
		else $error("short form timing");
	a_long_timing: assert property ((sb || mk || xr) && !sh |-> ##9 !o_done ##1 o_done)
		else $error("long form timing");
	a_swap_timing: assert property (sw |-> ##7 !o_done ##1 o_done)
		else $error("swap timing");
	c_borrow: cover property (sb ##1 o_flags[7]);
	c_mask: cover property (mk ##1 o_flags[6]);
	c_swap: cover property (sw ##8 o_done);
endmodule // asstx_alu_monitor
bind asstx_alu asstx_alu_monitor u_mon (
	.i_core_clk(i_core_clk),
	.i_reset_n(i_reset_n),
	.i_start(i_start),
	.i_opcode(i_opcode),
	.i_dst_data(i_dst_data),
	.i_src_data(i_src_data),
	.o_busy(o_busy),
	.o_done(o_done),
	.o_wr_en(o_wr_en),
	.o_wr_data(o_wr_data),
	.o_flags(o_flags)
);

//--- sim/asstx_regfile_model.sv
// register file model standing in for the core's operand store
`timescale 1ns/10ps
module asstx_regfile_model (
	// clock
	input wire i_core_clk,
	// write back from the datapath
	input wire i_wr_en,
	input wire [7:0] i_wr_data,
	// operand bytes to the datapath
	output wire [7:0] o_dst_data,
	output wire [7:0] o_src_data
);
	// destination lives in slot 1, source in slot 2
	reg [7:0] mem [0:3];
	assign o_dst_data = mem[1];
	assign o_src_data = mem[2];
	// only the destination slot takes write back
	always @(posedge i_core_clk) begin
		if (i_wr_en) begin
			mem[1] <= i_wr_data;
		end
	end
endmodule // asstx_regfile_model

//--- sim/alu_sub_swap_test_xor_bench.sv
// self-checking bench for the datapath slice
`timescale 1ns/10ps
`define chk(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module alu_sub_swap_test_xor_bench;
	reg i_core_clk = 0;
	reg i_reset_n = 0;
	reg i_start = 0;
	reg [7:0] i_opcode = 8'h00;
	reg i_flags_load = 0;
	reg [7:0] i_flags_data = 8'h00;
	reg [7:0] i_dst_addr = 8'he1;
	reg [7:0] i_src_addr = 8'he2;
	wire o_busy;
	wire o_illegal;
	wire o_dst_work;
	wire [3:0] o_dst_wreg;
	wire o_src_work;
	wire [3:0] o_src_wreg;
	wire o_pointer_operand_mode;
	wire o_literal_operand_mode;
	wire o_done;
	wire o_wr_en;
	wire [7:0] o_wr_data;
	wire [7:0] o_flags;
	wire [7:0] dd;
	wire [7:0] sd;
	int fail_count = 0;
	int checked = 0;
	always #12.5 i_core_clk = ~i_core_clk;
	asstx_regfile_model rf (.i_core_clk(i_core_clk), .i_wr_en(o_wr_en), .i_wr_data(o_wr_data),
		.o_dst_data(dd), .o_src_data(sd));
	asstx_alu dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_start(i_start),
		.i_opcode(i_opcode), .i_dst_data(dd), .i_src_data(sd), .i_dst_addr(i_dst_addr),
		.i_src_addr(i_src_addr), .i_flags_load(i_flags_load), .i_flags_data(i_flags_data),
		.o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_wr_en(o_wr_en),
		.o_wr_data(o_wr_data), .o_flags(o_flags), .o_dst_work(o_dst_work),
		.o_dst_wreg(o_dst_wreg), .o_src_work(o_src_work), .o_src_wreg(o_src_wreg),
		.o_pointer_operand_mode(o_pointer_operand_mode),
		.o_literal_operand_mode(o_literal_operand_mode));
	// one instruction: load operands, start, time it, let write back land
	task automatic run(input [7:0] op, input [7:0] d, input [7:0] s, input int cyc);
		int n = 0;
		rf.mem[1] = d;
		rf.mem[2] = s;
		i_opcode = op;
		i_start = 1;
		@(posedge i_core_clk) #1 i_start = 0;
		`chk("busy", 1'b1, o_busy)
		while (o_done !== 1'b1 && n < 20) begin
			@(posedge i_core_clk) #1 n++;
		end
		`chk("cycles", cyc, n + 1)
		@(posedge i_core_clk) #1;
		`chk("source", s, rf.mem[2])
	endtask
	task t_sub;
		run(8'h26, 8'h29, 8'h11, 10);
		`chk("diff", 8'h18, rf.mem[1])
		`chk("flags", 8'h08, o_flags)
		run(8'h22, 8'h80, 8'h01, 6);
		`chk("diff", 8'h7f, rf.mem[1])
		`chk("flags", 8'h1c, o_flags)
		run(8'h23, 8'h05, 8'h06, 6);
		`chk("flags", 8'hac, o_flags)
	endtask
	task t_swap;
		run(8'hf1, 8'hb3, 8'h00, 8);
		`chk("swap", 8'h3b, rf.mem[1])
		`chk("flags", 8'h0c, o_flags & 8'h6c)
	endtask
	task t_mask;
		i_flags_load = 1;
		i_flags_data = 8'hff;
		@(posedge i_core_clk) #1 i_flags_load = 0;
		run(8'h76, 8'hf6, 8'h06, 10);
		`chk("dst", 8'hf6, rf.mem[1])
		`chk("flags", 8'h8c, o_flags & 8'hfc)
		run(8'h72, 8'hf6, 8'h09, 6);
		`chk("flags", 8'hcc, o_flags & 8'hfc)
	endtask
	task t_xor;
		run(8'hb6, 8'hc3, 8'h7b, 10);
		`chk("xor", 8'hb8, rf.mem[1])
		`chk("flags", 8'hac, o_flags & 8'hfc)
	endtask
	task t_forms;
		for (int l = 2; l < 8; l++) begin
			run({4'h2, l[3:0]}, 8'h5a, 8'h3c, l < 4 ? 6 : 10);
			run({4'h7, l[3:0]}, 8'h5a, 8'h3c, l < 4 ? 6 : 10);
			run({4'hb, l[3:0]}, 8'h5a, 8'h3c, l < 4 ? 6 : 10);
		end
		run(8'hf0, 8'h5a, 8'h00, 8);
	endtask
	// operand address decode, address modes and a refused opcode
	task t_decode;
		i_dst_addr = 8'h35;
		i_src_addr = 8'he7;
		run(8'h25, 8'h5a, 8'h3c, 10);
		`chk("dst work", 1'b0, o_dst_work)
		`chk("dst wreg", 4'h5, o_dst_wreg)
		`chk("src work", 1'b1, o_src_work)
		`chk("src wreg", 4'h7, o_src_wreg)
		`chk("pointer", 1'b1, o_pointer_operand_mode)
		`chk("literal", 1'b0, o_literal_operand_mode)
		run(8'h76, 8'h5a, 8'h3c, 10);
		`chk("literal", 1'b1, o_literal_operand_mode)
		`chk("pointer", 1'b0, o_pointer_operand_mode)
		i_opcode = 8'h28;
		i_start = 1;
		@(posedge i_core_clk) #1 i_start = 0;
		`chk("illegal", 1'b1, o_illegal)
		`chk("busy", 1'b0, o_busy)
		@(posedge i_core_clk) #1;
		`chk("illegal", 1'b0, o_illegal)
	endtask
	// verdict and end of run
	task test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#50000;
		fail_count++;
		test_done;
	end
	// main sequence
	initial begin
		repeat (4) @(posedge i_core_clk);
		#1 i_reset_n = 1;
		t_sub;
		t_swap;
		t_mask;
		t_xor;
		t_forms;
		t_decode;
		test_done;
	end
endmodule // alu_sub_swap_test_xor_bench
